/* File: synth_radio_config.sv */
// synthesizer and modem configuration registers behind the serial configuration port
// Summary of operation
// - writing go bit starts automatic VCO ranging
// - go bit reads set until ranging ends
// - fail flag zero means ranging succeeded
// - receiver active shifts synthesizer by IF offset
// - IF offset resets to 1 MHz, writable
// - carrier word 1 Hz steps, shared by TX/RX
// - loop filter: nominal, times two, times five
// - three-bit charge pump current field
// - four-bit PA output level in transmit
// - one modulation setting for transmitter and receiver
// - channel filter decimation spans 4.8-600 kHz
// - receive rate relative to filter; separate TX rate
// - deviation drives transmitter only
// - timing gain sets receiver recovery aggressiveness
`timescale 1ns/1ps
`default_nettype none
module synth_radio_config (
    input wire logic clk,
    input wire logic nrst,
    input wire logic spi_sel_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic vco_in_range,
    output logic [3:0] vco_range,
    output logic [31:0] synth_carrier_word_a_word,
    output logic [1:0] loop_filter_sel,
    output logic [2:0] pump_current_sel,
    output logic low_band_select,
    output logic [3:0] pa_power_level,
    output logic [2:0] modulation_sel,
    output logic [12:0] chan_filter_decim,
    output logic [15:0] rx_rate,
    output logic [15:0] timing_gain,
    output logic [15:0] tx_bit_rate,
    output logic [15:0] tx_deviation,
    output logic rx_active,
    output logic tx_active
);
    // configuration storage
    logic [7:0] ctrl_reg;
    logic [31:0] carrier_word_a_reg;
    logic [15:0] if_offset_reg;
    logic [7:0] synth_loop_config_reg;
    logic [3:0] tx_power_reg;
    logic [2:0] modulation_reg;
    logic [12:0] decim_reg;
    logic [15:0] rx_rate_reg;
    logic [15:0] timing_gain_reg;
    logic [15:0] tx_rate_reg;
    logic [15:0] tx_dev_reg;
    logic [31:0] synth_carrier_word_a_reg;

    // serial port state
    logic sclk_q;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_in_reg;
    logic [6:0] addr_reg;
    logic write_reg;
    logic [7:0] shift_out_reg;
    logic go_pending_reg;

    // ranging sequencer
    logic rng_busy;
    logic rng_fail;
    logic ranging_go_flag;
    logic ranging_go_flag_q;

    // clamp a decimation request into the supported filter span
    function automatic logic [12:0] clamp_decim(input logic [12:0] value);
        if (value < synth_radio_pkg::DECIM_MIN) begin
            return synth_radio_pkg::DECIM_MIN;
        end else if (value > synth_radio_pkg::DECIM_MAX) begin
            return synth_radio_pkg::DECIM_MAX;
        end
        return value;
    endfunction

    // the reserved filter code falls back to nominal bandwidth
    function automatic logic [7:0] legal_loop(input logic [7:0] value);
        logic [7:0] v;
        v = value;
        if (v[synth_radio_pkg::LOOP_FILTER_LSB +: 2] == 2'h3) begin
            v[synth_radio_pkg::LOOP_FILTER_LSB +: 2] = synth_radio_pkg::FILTER_NOMINAL;
        end
        return v;
    endfunction

    // serial edge detection; pins are synchronous to clk
    wire sclk_rise = spi_sclk & ~sclk_q & ~spi_sel_n;
    wire sclk_fall = ~spi_sclk & sclk_q & ~spi_sel_n;
    wire [7:0] byte_in = {shift_in_reg[6:0], spi_mosi};
    wire addr_done = sclk_rise & (bit_cnt_reg == 4'h7);
    wire wr_en = sclk_rise & (bit_cnt_reg == 4'hf) & write_reg;
    wire [7:0] wr_data = byte_in;
    wire [6:0] rd_addr = byte_in[6:0];
    wire go_write = wr_en & (addr_reg == synth_radio_pkg::ADDR_RANGING) & wr_data[synth_radio_pkg::RANGING_GO_BIT];
    wire [15:0] if_scaled_hi = if_offset_reg;

    // read multiplexer
    logic [7:0] rd_data;
    always_comb begin
        case (rd_addr)
            synth_radio_pkg::ADDR_RADIO_CTRL: rd_data = ctrl_reg;
            synth_radio_pkg::ADDR_MODULATION: rd_data = {5'h00, modulation_reg};
            synth_radio_pkg::ADDR_CARRIER_WORD_A_3: rd_data = carrier_word_a_reg[31:24];
            synth_radio_pkg::ADDR_CARRIER_WORD_A_2: rd_data = carrier_word_a_reg[23:16];
            synth_radio_pkg::ADDR_CARRIER_WORD_A_1: rd_data = carrier_word_a_reg[15:8];
            synth_radio_pkg::ADDR_CARRIER_WORD_A_0: rd_data = carrier_word_a_reg[7:0];
            synth_radio_pkg::ADDR_IF_HIGH: rd_data = if_offset_reg[15:8];
            synth_radio_pkg::ADDR_IF_LOW: rd_data = if_offset_reg[7:0];
            synth_radio_pkg::ADDR_LOOP_CONFIG: rd_data = synth_loop_config_reg;
            synth_radio_pkg::ADDR_RANGING: rd_data = {2'h0, rng_fail, go_pending_reg, vco_range};
            synth_radio_pkg::ADDR_TX_POWER: rd_data = {4'h0, tx_power_reg};
            synth_radio_pkg::ADDR_DECIM_HIGH: rd_data = {3'h0, decim_reg[12:8]};
            synth_radio_pkg::ADDR_DECIM_LOW: rd_data = decim_reg[7:0];
            synth_radio_pkg::ADDR_RX_RATE_HIGH: rd_data = rx_rate_reg[15:8];
            synth_radio_pkg::ADDR_RX_RATE_LOW: rd_data = rx_rate_reg[7:0];
            synth_radio_pkg::ADDR_TIMING_HIGH: rd_data = timing_gain_reg[15:8];
            synth_radio_pkg::ADDR_TIMING_LOW: rd_data = timing_gain_reg[7:0];
            synth_radio_pkg::ADDR_TX_RATE_HIGH: rd_data = tx_rate_reg[15:8];
            synth_radio_pkg::ADDR_TX_RATE_LOW: rd_data = tx_rate_reg[7:0];
            synth_radio_pkg::ADDR_TX_DEV_HIGH: rd_data = tx_dev_reg[15:8];
            synth_radio_pkg::ADDR_TX_DEV_LOW: rd_data = tx_dev_reg[7:0];
            default: rd_data = 8'h00;
        endcase
    end

    // serial shift engine: first byte is write flag and address, second is data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_q <= 1'b0;
            bit_cnt_reg <= 4'h0;
            shift_in_reg <= 8'h00;
            addr_reg <= 7'h00;
            write_reg <= 1'b0;
            shift_out_reg <= 8'h00;
        end else begin
            sclk_q <= spi_sclk;
            if (spi_sel_n) begin
                bit_cnt_reg <= 4'h0;
            end else if (sclk_rise) begin
                shift_in_reg <= byte_in;
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (addr_done) begin
                    write_reg <= shift_in_reg[6];
                    addr_reg <= rd_addr;
                    shift_out_reg <= rd_data;
                end
            end else if (sclk_fall && bit_cnt_reg >= 4'h9) begin
                // data bit 7 stays on miso until the ninth rise has sampled it
                shift_out_reg <= {shift_out_reg[6:0], 1'b0};
            end
        end
    end

    // go bit: a start request is ignored while go is still set, so it never meets completion in one cycle
    assign ranging_go_flag = go_write & ~go_pending_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            go_pending_reg <= 1'b0;
        end else if (ranging_go_flag) begin
            go_pending_reg <= 1'b1;
        end else if (go_pending_reg && !rng_busy && !ranging_go_flag_q) begin
            go_pending_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ranging_go_flag_q <= 1'b0;
        end else begin
            ranging_go_flag_q <= ranging_go_flag;
        end
    end

    // register writes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= 8'h00;
            carrier_word_a_reg <= synth_radio_pkg::CARRIER_WORD_A_RESET;
            if_offset_reg <= synth_radio_pkg::IF_RESET;
            synth_loop_config_reg <= synth_radio_pkg::LOOP_CONFIG_RESET;
            tx_power_reg <= synth_radio_pkg::TX_POWER_RESET;
            modulation_reg <= synth_radio_pkg::MODULATION_RESET;
            decim_reg <= synth_radio_pkg::DECIM_RESET;
            rx_rate_reg <= synth_radio_pkg::RX_RATE_RESET;
            timing_gain_reg <= synth_radio_pkg::TIMING_RESET;
            tx_rate_reg <= synth_radio_pkg::TX_RATE_RESET;
            tx_dev_reg <= synth_radio_pkg::TX_DEV_RESET;
        end else if (wr_en) begin
            case (addr_reg)
                synth_radio_pkg::ADDR_RADIO_CTRL: ctrl_reg <= {6'h00, wr_data[1:0]};
                synth_radio_pkg::ADDR_MODULATION: modulation_reg <= wr_data[2:0];
                synth_radio_pkg::ADDR_CARRIER_WORD_A_3: carrier_word_a_reg[31:24] <= wr_data;
                synth_radio_pkg::ADDR_CARRIER_WORD_A_2: carrier_word_a_reg[23:16] <= wr_data;
                synth_radio_pkg::ADDR_CARRIER_WORD_A_1: carrier_word_a_reg[15:8] <= wr_data;
                synth_radio_pkg::ADDR_CARRIER_WORD_A_0: carrier_word_a_reg[7:0] <= wr_data;
                synth_radio_pkg::ADDR_IF_HIGH: if_offset_reg[15:8] <= wr_data;
                synth_radio_pkg::ADDR_IF_LOW: if_offset_reg[7:0] <= wr_data;
                synth_radio_pkg::ADDR_LOOP_CONFIG: synth_loop_config_reg <= legal_loop(wr_data);
                synth_radio_pkg::ADDR_TX_POWER: tx_power_reg <= wr_data[3:0];
                synth_radio_pkg::ADDR_DECIM_HIGH: decim_reg <= clamp_decim({wr_data[4:0], decim_reg[7:0]});
                synth_radio_pkg::ADDR_DECIM_LOW: decim_reg <= clamp_decim({decim_reg[12:8], wr_data});
                synth_radio_pkg::ADDR_RX_RATE_HIGH: rx_rate_reg[15:8] <= wr_data;
                synth_radio_pkg::ADDR_RX_RATE_LOW: rx_rate_reg[7:0] <= wr_data;
                synth_radio_pkg::ADDR_TIMING_HIGH: timing_gain_reg[15:8] <= wr_data;
                synth_radio_pkg::ADDR_TIMING_LOW: timing_gain_reg[7:0] <= wr_data;
                synth_radio_pkg::ADDR_TX_RATE_HIGH: tx_rate_reg[15:8] <= wr_data;
                synth_radio_pkg::ADDR_TX_RATE_LOW: tx_rate_reg[7:0] <= wr_data;
                synth_radio_pkg::ADDR_TX_DEV_HIGH: tx_dev_reg[15:8] <= wr_data;
                synth_radio_pkg::ADDR_TX_DEV_LOW: tx_dev_reg[7:0] <= wr_data;
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    // synthesizer word: receive mixes down by the IF offset, 1 Hz per step
    wire [31:0] if_offset_hz = 32'(if_scaled_hi) * 32'(synth_radio_pkg::IF_STEP_HZ);
    wire rx_on = ctrl_reg[synth_radio_pkg::CTRL_RX_BIT];
    wire [31:0] synth_carrier_word_a_next = rx_on ? (carrier_word_a_reg - if_offset_hz) : carrier_word_a_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            synth_carrier_word_a_reg <= synth_radio_pkg::CARRIER_WORD_A_RESET;
        end else begin
            synth_carrier_word_a_reg <= synth_carrier_word_a_next;
        end
    end

    vco_ranging_seq u_ranging (
        .clk(clk),
        .nrst(nrst),
        .start(ranging_go_flag_q),
        .vco_in_range(vco_in_range),
        .busy(rng_busy),
        .fail(rng_fail),
        .vco_range(vco_range)
    );

    assign spi_miso = shift_out_reg[7];
    assign spi_miso_oe = ~spi_sel_n;
    assign synth_carrier_word_a_word = synth_carrier_word_a_reg;
    assign loop_filter_sel = synth_loop_config_reg[synth_radio_pkg::LOOP_FILTER_LSB +: 2];
    assign pump_current_sel = synth_loop_config_reg[synth_radio_pkg::LOOP_PUMP_LSB +: 3];
    assign low_band_select = synth_loop_config_reg[synth_radio_pkg::LOOP_BAND_BIT];
    assign pa_power_level = tx_power_reg;
    assign modulation_sel = modulation_reg;
    assign chan_filter_decim = decim_reg;
    assign rx_rate = rx_rate_reg;
    assign timing_gain = timing_gain_reg;
    assign tx_bit_rate = tx_rate_reg;
    assign tx_deviation = tx_dev_reg;
    assign rx_active = rx_on;
    assign tx_active = ctrl_reg[synth_radio_pkg::CTRL_TX_BIT];
endmodule // synth_radio_config
`default_nettype wire

/* File: synth_radio_config_sva.sv */
// concurrent checks on the ports of the synthesizer configuration block
`timescale 1ns/1ps
`default_nettype none
module synth_radio_config_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic spi_sel_n,
    input wire logic spi_miso_oe,
    input wire logic [3:0] vco_range,
    input wire logic [31:0] synth_carrier_word_a_word,
    input wire logic [1:0] loop_filter_sel,
    input wire logic [3:0] pa_power_level,
    input wire logic [2:0] modulation_sel,
    input wire logic [12:0] chan_filter_decim,
    input wire logic rx_active
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // port idle for three samples: no write can still be landing
    sequence s_port_idle;
        spi_sel_n [*3];
    endsequence
    // one vco range is held while the comparator settles
    sequence s_range_hold;
        $stable(vco_range) [*8];
    endsequence
    property p_word_moves_after(logic ev);
        ev |=> $changed(synth_carrier_word_a_word);
    endproperty

    a_miso_drive_select: assert property (spi_miso_oe == !spi_sel_n)
        else $error("miso enable does not follow select");
    a_filter_code_legal: assert property (loop_filter_sel != 2'h3)
        else $error("loop filter holds the unused code");
    a_decim_in_range: assert property (chan_filter_decim >= 13'h0002 && chan_filter_decim <= 13'h00fa)
        else $error("channel filter decimation outside its span");
    a_modulation_code_legal: assert property (modulation_sel <= 3'h6)
        else $error("modulation code out of range");
    a_regs_quiet_idle: assert property (s_port_idle |-> $stable(pa_power_level) && $stable(modulation_sel)
        && $stable(chan_filter_decim) && $stable(synth_carrier_word_a_word))
        else $error("configuration output moved with the port idle");
    a_rx_shift_applied: assert property (p_word_moves_after($rose(rx_active)))
        else $error("synthesizer word not shifted on receive entry");
    a_rx_shift_removed: assert property (p_word_moves_after($fell(rx_active)))
        else $error("synthesizer word not restored on receive exit");
    a_range_step_hold: assert property ($changed(vco_range) |=> s_range_hold)
        else $error("vco range stepped without settling");
endmodule // synth_radio_config_chk

bind synth_radio_config synth_radio_config_chk i_synth_radio_config_chk (.clk(clk), .nrst(nrst),
    .spi_sel_n(spi_sel_n), .spi_miso_oe(spi_miso_oe), .vco_range(vco_range),
    .synth_carrier_word_a_word(synth_carrier_word_a_word), .loop_filter_sel(loop_filter_sel), .pa_power_level(pa_power_level),
    .modulation_sel(modulation_sel), .chan_filter_decim(chan_filter_decim), .rx_active(rx_active));
`default_nettype wire

/* File: synth_radio_config_tb_top.sv */
// self-checking testbench for the synthesizer configuration block
`timescale 1ns/1ps
`default_nettype none
module synth_radio_config_tb_top;
    logic clk, nrst, spi_sel_n, spi_sclk, spi_mosi, vco_in_range;
    logic spi_miso, spi_miso_oe, low_band_select, rx_active, tx_active;
    logic [3:0] vco_range, pa_power_level;
    logic [31:0] synth_carrier_word_a_word;
    logic [1:0] loop_filter_sel;
    logic [2:0] pump_current_sel, modulation_sel;
    logic [12:0] chan_filter_decim;
    logic [15:0] rx_rate, timing_gain, tx_bit_rate, tx_deviation;
    int bad_count = 0;
    int total_checks = 0;

    synth_radio_config i_synth_radio_config (.clk(clk), .nrst(nrst), .spi_sel_n(spi_sel_n),
        .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .vco_in_range(vco_in_range), .vco_range(vco_range), .synth_carrier_word_a_word(synth_carrier_word_a_word),
        .loop_filter_sel(loop_filter_sel), .pump_current_sel(pump_current_sel),
        .low_band_select(low_band_select), .pa_power_level(pa_power_level), .modulation_sel(modulation_sel),
        .chan_filter_decim(chan_filter_decim), .rx_rate(rx_rate), .timing_gain(timing_gain),
        .tx_bit_rate(tx_bit_rate), .tx_deviation(tx_deviation), .rx_active(rx_active), .tx_active(tx_active));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one 16-bit access; each serial clock level lasts two system clocks
    task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
        logic [15:0] word;
        word = {wr, addr, wdata};
        rdata = 8'h00;
        spi_sel_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_mosi = word[i];
            spi_sclk = 1'b0;
            step(2);
            if (i < 8) rdata[i] = spi_miso;
            spi_sclk = 1'b1;
            step(2);
        end
        spi_sclk = 1'b0;
        step(2);
        spi_sel_n = 1'b1;
        step(2);
    endtask

    task automatic wreg(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] unused;
        xfer(1'b1, a, d, unused);
    endtask

    task automatic rchk(input string name, input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] v;
        xfer(1'b0, a, 8'h00, v);
        cmp(name, 32'(exp), 32'(v));
    endtask

    task automatic test_reset;
        rchk("loop cfg", synth_radio_pkg::ADDR_LOOP_CONFIG, 8'h1c);
        rchk("if high", synth_radio_pkg::ADDR_IF_HIGH, 8'hf4);
        rchk("if low", synth_radio_pkg::ADDR_IF_LOW, 8'h24);
        cmp("pa level", 32'h0000_0008, 32'(pa_power_level));
        cmp("modulation", 32'h0000_0002, 32'(modulation_sel));
        cmp("decim", 32'h0000_0010, 32'(chan_filter_decim));
        cmp("rx rate", 32'h0000_0100, 32'(rx_rate));
        cmp("timing", 32'h0000_0040, 32'(timing_gain));
        cmp("tx rate", 32'h0000_0100, 32'(tx_bit_rate));
        cmp("deviation", 32'h0000_0200, 32'(tx_deviation));
        cmp("synth word", 32'h0000_0000, synth_carrier_word_a_word);
    endtask

    task automatic test_loop;
        logic [1:0] exp;
        for (int f = 0; f < 4; f++) begin
            wreg(synth_radio_pkg::ADDR_LOOP_CONFIG, {2'h2, 1'(f), 3'h5, 2'(f)});
            exp = (f == 3) ? 2'h0 : 2'(f);
            cmp("filter", 32'(exp), 32'(loop_filter_sel));
            cmp("pump", 32'h0000_0005, 32'(pump_current_sel));
            cmp("band", 32'(f % 2), 32'(low_band_select));
            rchk("loop back", synth_radio_pkg::ADDR_LOOP_CONFIG, {2'h2, 1'(f), 3'h5, exp});
        end
    endtask

    task automatic test_carrier_word_a;
        logic [31:0] carrier;
        carrier = 32'h1a2b_3c4d;
        for (int b = 0; b < 4; b++) begin
            wreg(synth_radio_pkg::ADDR_CARRIER_WORD_A_3 + 7'(b), carrier[31 - 8 * b -: 8]);
        end
        cmp("carrier", carrier, synth_carrier_word_a_word);
        wreg(synth_radio_pkg::ADDR_RADIO_CTRL, 8'h01);
        cmp("rx word", carrier - 32'h000f_4240, synth_carrier_word_a_word);
        cmp("rx flag", 32'h0000_0001, 32'(rx_active));
        wreg(synth_radio_pkg::ADDR_IF_HIGH, 8'h12);
        wreg(synth_radio_pkg::ADDR_IF_LOW, 8'h34);
        cmp("rx word new if", carrier - 32'h0001_2340, synth_carrier_word_a_word);
        rchk("if high", synth_radio_pkg::ADDR_IF_HIGH, 8'h12);
        wreg(synth_radio_pkg::ADDR_RADIO_CTRL, 8'h02);
        cmp("tx word", carrier, synth_carrier_word_a_word);
        cmp("tx flag", 32'h0000_0001, 32'(tx_active));
        wreg(synth_radio_pkg::ADDR_RADIO_CTRL, 8'h00);
    endtask

    task automatic test_modem;
        for (int m = 0; m < 7; m++) begin
            wreg(synth_radio_pkg::ADDR_MODULATION, 8'(m));
            cmp("modulation", 32'(m), 32'(modulation_sel));
        end
        wreg(synth_radio_pkg::ADDR_DECIM_HIGH, 8'h00);
        wreg(synth_radio_pkg::ADDR_DECIM_LOW, 8'h01);
        cmp("decim low clamp", 32'h0000_0002, 32'(chan_filter_decim));
        wreg(synth_radio_pkg::ADDR_DECIM_LOW, 8'hff);
        cmp("decim high clamp", 32'h0000_00fa, 32'(chan_filter_decim));
        wreg(synth_radio_pkg::ADDR_DECIM_LOW, 8'h80);
        wreg(synth_radio_pkg::ADDR_RX_RATE_HIGH, 8'h12);
        wreg(synth_radio_pkg::ADDR_RX_RATE_LOW, 8'h34);
        wreg(synth_radio_pkg::ADDR_TIMING_HIGH, 8'h0a);
        wreg(synth_radio_pkg::ADDR_TIMING_LOW, 8'hbc);
        wreg(synth_radio_pkg::ADDR_TX_RATE_HIGH, 8'h56);
        wreg(synth_radio_pkg::ADDR_TX_RATE_LOW, 8'h78);
        wreg(synth_radio_pkg::ADDR_TX_DEV_HIGH, 8'h9a);
        wreg(synth_radio_pkg::ADDR_TX_DEV_LOW, 8'hbc);
        wreg(synth_radio_pkg::ADDR_TX_POWER, 8'h0d);
        // port left idle for a while so that the quiet-port check is exercised
        step(4);
        cmp("timing", 32'h0000_0abc, 32'(timing_gain));
        cmp("tx rate", 32'h0000_5678, 32'(tx_bit_rate));
        cmp("deviation", 32'h0000_9abc, 32'(tx_deviation));
        cmp("rx rate", 32'h0000_1234, 32'(rx_rate));
        cmp("decim kept", 32'h0000_0080, 32'(chan_filter_decim));
        cmp("pa level", 32'h0000_000d, 32'(pa_power_level));
        wreg(7'h7f, 8'h5a);
        rchk("unmapped", 7'h7f, 8'h00);
    endtask

    // software polls the go bit before looking at the fail flag
    task automatic ranging_run(input logic good, input int limit);
        logic [7:0] rd;
        int n;
        vco_in_range = good;
        wreg(synth_radio_pkg::ADDR_RANGING, 8'h10);
        xfer(1'b0, synth_radio_pkg::ADDR_RANGING, 8'h00, rd);
        cmp("go while busy", 32'h0000_0001, 32'(rd[4]));
        n = 0;
        while (rd[4] !== 1'b0 && n < limit) begin
            xfer(1'b0, synth_radio_pkg::ADDR_RANGING, 8'h00, rd);
            n++;
        end
        cmp("go cleared", 32'h0000_0000, 32'(rd[4]));
        cmp("fail flag", 32'(!good), 32'(rd[5]));
    endtask

    task automatic test_ranging;
        ranging_run(1'b1, 100);
        cmp("good range", 32'h0000_0000, 32'(vco_range));
        ranging_run(1'b0, 400);
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        spi_sel_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
        vco_in_range = 1'b0;
        step(3);
        nrst = 1'b1;
        step(2);
        test_reset();
        test_loop();
        test_carrier_word_a();
        test_modem();
        test_ranging();
        finish_test();
    end

    // ranging failure dominates the run at about 20000 cycles
    initial begin
        repeat (80000) @(posedge clk);
        bad_count++;
        finish_test();
    end
endmodule // synth_radio_config_tb_top
`default_nettype wire

/* File: synth_radio_pkg.sv */
// constants shared by the synthesizer and modem configuration block
package synth_radio_pkg;
    // register addresses on the serial port (7-bit)
    localparam logic [6:0] ADDR_RADIO_CTRL = 7'h02;
    localparam logic [6:0] ADDR_MODULATION = 7'h10;
    localparam logic [6:0] ADDR_CARRIER_WORD_A_3 = 7'h20;
    localparam logic [6:0] ADDR_CARRIER_WORD_A_2 = 7'h21;
    localparam logic [6:0] ADDR_CARRIER_WORD_A_1 = 7'h22;
    localparam logic [6:0] ADDR_CARRIER_WORD_A_0 = 7'h23;
    localparam logic [6:0] ADDR_IF_HIGH = 7'h28;
    localparam logic [6:0] ADDR_IF_LOW = 7'h29;
    localparam logic [6:0] ADDR_LOOP_CONFIG = 7'h2c;
    localparam logic [6:0] ADDR_RANGING = 7'h2d;
    localparam logic [6:0] ADDR_TX_POWER = 7'h30;
    localparam logic [6:0] ADDR_DECIM_HIGH = 7'h40;
    localparam logic [6:0] ADDR_DECIM_LOW = 7'h41;
    localparam logic [6:0] ADDR_RX_RATE_HIGH = 7'h42;
    localparam logic [6:0] ADDR_RX_RATE_LOW = 7'h43;
    localparam logic [6:0] ADDR_TIMING_HIGH = 7'h44;
    localparam logic [6:0] ADDR_TIMING_LOW = 7'h45;
    localparam logic [6:0] ADDR_TX_RATE_HIGH = 7'h46;
    localparam logic [6:0] ADDR_TX_RATE_LOW = 7'h47;
    localparam logic [6:0] ADDR_TX_DEV_HIGH = 7'h48;
    localparam logic [6:0] ADDR_TX_DEV_LOW = 7'h49;

    // loop configuration field positions
    localparam int LOOP_FILTER_LSB = 0;
    localparam int LOOP_PUMP_LSB = 2;
    localparam int LOOP_BAND_BIT = 5;
    // ranging register field positions
    localparam int RANGING_GO_BIT = 4;
    localparam int RANGING_FAIL_BIT = 5;
    // control register field positions
    localparam int CTRL_RX_BIT = 0;
    localparam int CTRL_TX_BIT = 1;

    // loop filter settings
    localparam logic [1:0] FILTER_NOMINAL = 2'h0;
    localparam logic [1:0] FILTER_X2 = 2'h1;
    localparam logic [1:0] FILTER_X5 = 2'h2;

    typedef enum logic [2:0] {
        MOD_ASK, MOD_PSK, MOD_FSK, MOD_MSK, MOD_GFSK, MOD_GMSK, MOD_OQPSK
    } modulation_t;

    // reset values
    localparam logic [7:0] LOOP_CONFIG_RESET = 8'h1c;
    localparam logic [15:0] IF_STEP_HZ = 16'h0010;
    localparam logic [15:0] IF_RESET = 16'hf424;     // 62500 steps of 16 Hz = 1 MHz
    localparam logic [31:0] CARRIER_WORD_A_RESET = 32'h0000_0000;
    localparam logic [3:0] TX_POWER_RESET = 4'h8;
    localparam logic [2:0] MODULATION_RESET = 3'h2;
    localparam logic [12:0] DECIM_MIN = 13'h0002;    // widest filter, 600 kHz
    localparam logic [12:0] DECIM_MAX = 13'h00fa;    // 125 times narrower, 4.8 kHz
    localparam logic [12:0] DECIM_RESET = 13'h0010;
    localparam logic [15:0] RX_RATE_RESET = 16'h0100;
    localparam logic [15:0] TIMING_RESET = 16'h0040;
    localparam logic [15:0] TX_RATE_RESET = 16'h0100;
    localparam logic [15:0] TX_DEV_RESET = 16'h0200;

    // auto-ranging timing
    localparam int CLK_HZ = 25000000;
    localparam int VCO_SETTLE_US = 50;
    localparam int VCO_SETTLE_CYCLES = (VCO_SETTLE_US * (CLK_HZ / 1000000));
    localparam logic [3:0] VCO_RANGE_LAST = 4'hf;
    localparam logic [3:0] VCO_RANGE_RESET = 4'h8;
endpackage

/* File: vco_ranging_seq.sv */
// vco auto-ranging sequencer: steps through vco ranges until the tuning voltage is in window
`timescale 1ns/1ps
`default_nettype none
module vco_ranging_seq (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic vco_in_range,
    output logic busy,
    output logic fail,
    output logic [3:0] vco_range
);
    typedef enum logic [1:0] {RNG_IDLE, RNG_SETTLE, RNG_CHECK} rng_state_t;

    rng_state_t state_reg;
    logic [11:0] settle_reg;
    logic [3:0] range_reg;
    logic fail_reg;

    wire settled = (settle_reg == 12'(synth_radio_pkg::VCO_SETTLE_CYCLES - 1));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= RNG_IDLE;
            settle_reg <= 12'h000;
            range_reg <= synth_radio_pkg::VCO_RANGE_RESET;
            fail_reg <= 1'b0;
        end else begin
            case (state_reg)
                RNG_IDLE: begin
                    if (start) begin
                        state_reg <= RNG_SETTLE;
                        range_reg <= 4'h0;
                        settle_reg <= 12'h000;
                        fail_reg <= 1'b0;
                    end
                end
                RNG_SETTLE: begin
                    settle_reg <= settle_reg + 12'h001;
                    if (settled) begin
                        state_reg <= RNG_CHECK;
                    end
                end
                RNG_CHECK: begin
                    settle_reg <= 12'h000;
                    if (vco_in_range) begin
                        state_reg <= RNG_IDLE;
                    end else if (range_reg == synth_radio_pkg::VCO_RANGE_LAST) begin
                        fail_reg <= 1'b1;
                        state_reg <= RNG_IDLE;
                    end else begin
                        range_reg <= range_reg + 4'h1;
                        state_reg <= RNG_SETTLE;
                    end
                end
                default: state_reg <= RNG_IDLE;
            endcase
        end
    end

    assign busy = (state_reg != RNG_IDLE);
    assign fail = fail_reg;
    assign vco_range = range_reg;
endmodule // vco_ranging_seq
`default_nettype wire
